// *** design/aar_pkg.sv ***
// Package: register map, field positions and carrier types for the alarm/start bank
package aar_pkg;
	localparam logic [6:0] ADDR_ALARM_MASK = 7'h05;
	localparam logic [6:0] ADDR_SDO_CFG = 7'h06;
	localparam logic [6:0] ADDR_SOFT_RESET = 7'h07;
	localparam logic [6:0] ADDR_START = 7'h0F;
	localparam logic [6:0] ADDR_CONV_CFG = 7'h04;
	localparam logic [6:0] ADDR_LOCK = 7'h08;
	localparam logic [6:0] ADDR_STATE = 7'h10;
	localparam int BIT_BROWNOUT_MASK = 7;
	localparam int BIT_DGAIN_MASK = 6;
	localparam int BIT_AMP_MASK = 0;
	localparam int BIT_SDO_DRIVE = 0;
	localparam int BIT_SOFT_RESET = 0;
	localparam int BIT_POWER_MODE = 0;
	localparam int BIT_SINGLE_SHOT = 1;
	localparam int BIT_LOCK = 0;
	localparam int BIT_READY = 0;
	localparam int BIT_BUSY = 1;
	localparam logic [7:0] ALARM_MASK_RESET = 8'h00;
	localparam logic [7:0] ALARM_MASK_WMASK = 8'hC1;
	localparam logic [15:0] ERROR_CODE = 16'h7FFF;
	localparam int NUM_CH = 3;
	localparam logic [1:0] CH_LAST = 2'h2;
	// Per-channel converter flags from the analog side
	typedef struct packed {
		logic dgain_ovr;
		logic amp_ovr;
	} aar_ch_flags_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] data;
	} aar_reg_req_t;
	typedef enum logic [1:0] {
		AAR_IDLE,
		AAR_RUN,
		AAR_DONE
	} aar_seq_state_t;
endpackage

// *** design/aar_spi_slave.sv ***
// SPI slave: frames 16-bit transfers (R/W, 7-bit address, 8-bit data), mode 0
`timescale 1ns/100ps
`default_nettype none
module aar_spi_slave
	import aar_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic sclk_i,
	input wire logic csn_i,
	input wire logic sdi_i,
	input wire logic [7:0] rd_data_i,
	output aar_reg_req_t req_o,
	output logic rd_phase_o,
	output logic sdo_bit_o
);
	logic [1:0] sclk_sync_reg;
	logic [1:0] csn_sync_reg;
	logic [1:0] sdi_sync_reg;
	logic sclk_prev_reg;
	logic [3:0] bit_cnt_reg;
	logic [14:0] shift_reg;
	logic [7:0] out_reg;
	logic is_read_reg;
	wire logic rise = sclk_sync_reg[1] & ~sclk_prev_reg & ~csn_sync_reg[1];
	wire logic fall = ~sclk_sync_reg[1] & sclk_prev_reg & ~csn_sync_reg[1];

	// Link pins are asynchronous to sys_clk; two stages before use
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_sync_reg <= 2'h0;
			csn_sync_reg <= 2'h3;
			sdi_sync_reg <= 2'h0;
			sclk_prev_reg <= 1'b0;
		end else if (ce_i) begin
			sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
			csn_sync_reg <= {csn_sync_reg[0], csn_i};
			sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
			sclk_prev_reg <= sclk_sync_reg[1];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt_reg <= 4'h0;
			shift_reg <= 15'h0000;
			is_read_reg <= 1'b0;
			req_o <= '0;
		end else if (ce_i) begin
			req_o.wr <= 1'b0;
			req_o.rd <= 1'b0;
			if (csn_sync_reg[1]) begin
				bit_cnt_reg <= 4'h0;
				is_read_reg <= 1'b0;
			end else if (rise) begin
				shift_reg <= {shift_reg[13:0], sdi_sync_reg[1]};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (bit_cnt_reg == 4'h7) begin
					is_read_reg <= shift_reg[6];
					req_o.rd <= shift_reg[6];
					req_o.addr <= {shift_reg[5:0], sdi_sync_reg[1]};
				end
				if (bit_cnt_reg == 4'hF && !is_read_reg) begin
					req_o.wr <= 1'b1;
					req_o.data <= {shift_reg[6:0], sdi_sync_reg[1]};
				end
			end
		end
	end

	// Read data shifts out on falling edges during the data byte
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_reg <= 8'h00;
			rd_phase_o <= 1'b0;
		end else if (ce_i) begin
			if (req_o.rd) begin
				out_reg <= rd_data_i;
				rd_phase_o <= 1'b1;
			end else if (csn_sync_reg[1]) begin
				rd_phase_o <= 1'b0;
			end else if (fall && rd_phase_o && bit_cnt_reg != 4'h8) begin
				out_reg <= {out_reg[6:0], 1'b0};
			end
		end
	end
	assign sdo_bit_o = out_reg[7];
endmodule
`default_nettype wire

// *** design/aar_result_gate.sv ***
// Alarm gating: replaces a channel result with the error code per the masks
`timescale 1ns/100ps
`default_nettype none
module aar_result_gate
	import aar_pkg::*;
(
	input wire logic [7:0] alarm_mask_i,
	input wire logic brownout_i,
	input wire logic ch_enabled_i,
	input wire aar_ch_flags_t flags_i,
	input wire logic [15:0] raw_i,
	output logic [15:0] result_o
);
	logic force_err;
	always_comb begin
		force_err = 1'b0;
		if (brownout_i && !alarm_mask_i[BIT_BROWNOUT_MASK] && ch_enabled_i)
			force_err = 1'b1;
		if (flags_i.dgain_ovr && !alarm_mask_i[BIT_DGAIN_MASK])
			force_err = 1'b1;
		if (flags_i.amp_ovr && !alarm_mask_i[BIT_AMP_MASK])
			force_err = 1'b1;
		result_o = force_err ? ERROR_CODE : raw_i;
	end
endmodule
`default_nettype wire

// *** design/aar_regs.sv ***
// Alarm mask, SDO drive, soft reset and start trigger register bank
//
// Behaviour
// - With the brown-out mask clear, a brown-out forces every enabled channel result to 0x7FFF.
// - With the brown-out mask set, a brown-out leaves results unchanged.
// - With the digital-gain mask clear, a channel's digital-gain over-range forces only its result to 0x7FFF.
// - With the digital-gain mask set, digital-gain over-range leaves the result alone.
// - The amplifier over-range mask, when clear, forces that channel's result to 0x7FFF, and when set has no effect.
// - With the SDO drive bit clear (reset value) SDO is driven only during read-back and is released otherwise.
// - With the SDO drive bit set, SDO is driven high except during read-back, when it carries read data.
// - Writing one to the soft-reset bit returns every other register to its default value; the soft-reset bit itself stays one until written zero.
// - The start register is write-only, reads as zero, and a write to it triggers conversion only while the power-mode and lock bits are both set.
// - In continuous mode one start write launches a round robin that repeats indefinitely.
// - In single-shot mode each start write converts every enabled channel once, then waits.
`timescale 1ns/100ps
`default_nettype none
module aar_regs
	import aar_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic sclk_i,
	input wire logic csn_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic sync_i,
	input wire logic brownout_i,
	input wire logic [2:0] ch_enable_i,
	input wire aar_ch_flags_t [2:0] ch_flags_i,
	input wire logic [47:0] ch_raw_i,
	input wire logic conv_done_i,
	output logic [47:0] ch_result_o,
	output logic conv_go_o,
	output logic [1:0] conv_ch_o,
	output logic conv_active_o
);
	logic [1:0] rst_sync_reg;
	wire logic rst_n = rst_sync_reg[1];
	logic [1:0] sync_pin_reg;
	logic sync_prev_reg;
	logic [7:0] alarm_mask_reg;
	logic sdo_drive_reg;
	logic soft_reset_reg;
	logic [1:0] conv_cfg_reg;
	logic lock_reg;
	aar_seq_state_t state_reg;
	aar_reg_req_t req;
	logic rd_phase;
	logic sdo_bit;
	logic [7:0] rd_data;
	logic start_trig;
	logic [47:0] gated;

	function automatic logic hit(input aar_reg_req_t r, input logic [6:0] a);
		hit = r.wr && r.addr == a;
	endfunction

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	aar_spi_slave u_spi (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n),
		.ce_i(ce_i),
		.sclk_i(sclk_i),
		.csn_i(csn_i),
		.sdi_i(sdi_i),
		.rd_data_i(rd_data),
		.req_o(req),
		.rd_phase_o(rd_phase),
		.sdo_bit_o(sdo_bit)
	);

	// Soft reset holds registers at default while the bit reads one
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset_reg <= 1'b0;
		end else if (ce_i && hit(req, ADDR_SOFT_RESET)) begin
			soft_reset_reg <= req.data[BIT_SOFT_RESET];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			alarm_mask_reg <= ALARM_MASK_RESET;
			sdo_drive_reg <= 1'b0;
			conv_cfg_reg <= 2'h0;
			lock_reg <= 1'b0;
		end else if (ce_i) begin
			if (soft_reset_reg) begin
				alarm_mask_reg <= ALARM_MASK_RESET;
				sdo_drive_reg <= 1'b0;
				conv_cfg_reg <= 2'h0;
				lock_reg <= 1'b0;
			end else begin
				if (hit(req, ADDR_ALARM_MASK) && !conv_cfg_reg[BIT_POWER_MODE])
					alarm_mask_reg <= req.data & ALARM_MASK_WMASK;
				if (hit(req, ADDR_SDO_CFG))
					sdo_drive_reg <= req.data[BIT_SDO_DRIVE];
				if (hit(req, ADDR_CONV_CFG) && !lock_reg)
					conv_cfg_reg <= req.data[1:0];
				if (hit(req, ADDR_LOCK))
					lock_reg <= req.data[BIT_LOCK];
			end
		end
	end
	always_comb begin
		case (req.addr)
			ADDR_ALARM_MASK: rd_data = alarm_mask_reg;
			ADDR_SDO_CFG: rd_data = {7'h00, sdo_drive_reg};
			ADDR_SOFT_RESET: rd_data = {7'h00, soft_reset_reg};
			ADDR_CONV_CFG: rd_data = {6'h00, conv_cfg_reg};
			ADDR_LOCK: rd_data = {7'h00, lock_reg};
			ADDR_STATE: rd_data = {6'h00, conv_active_o, ~soft_reset_reg};
			default: rd_data = 8'h00;
		endcase
	end

	// Sync pin is asynchronous: two stages, then edge detect
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sync_pin_reg <= 2'h0;
			sync_prev_reg <= 1'b0;
		end else if (ce_i) begin
			sync_pin_reg <= {sync_pin_reg[0], sync_i};
			sync_prev_reg <= sync_pin_reg[1];
		end
	end

	assign start_trig = conv_cfg_reg[BIT_POWER_MODE] && lock_reg &&
		(hit(req, ADDR_START) || (sync_pin_reg[1] && !sync_prev_reg));

	// Round-robin sequencer over enabled channels
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= AAR_IDLE;
			conv_ch_o <= 2'h0;
			conv_go_o <= 1'b0;
			conv_active_o <= 1'b0;
		end else if (ce_i) begin
			conv_go_o <= 1'b0;
			case (state_reg)
				AAR_IDLE: begin
					if (start_trig && !soft_reset_reg && ch_enable_i != 3'h0) begin
						state_reg <= AAR_RUN;
						conv_ch_o <= 2'h0;
						conv_go_o <= ch_enable_i[0];
						conv_active_o <= 1'b1;
					end
				end
				AAR_RUN: begin
					if (soft_reset_reg || !conv_cfg_reg[BIT_POWER_MODE]) begin
						state_reg <= AAR_IDLE;
						conv_active_o <= 1'b0;
					end else if (conv_done_i || !ch_enable_i[conv_ch_o]) begin
						if (conv_ch_o == CH_LAST) begin
							conv_ch_o <= 2'h0;
							if (conv_cfg_reg[BIT_SINGLE_SHOT]) begin
								state_reg <= AAR_DONE;
							end else begin
								conv_go_o <= ch_enable_i[0];
							end
						end else begin
							conv_ch_o <= conv_ch_o + 2'h1;
							conv_go_o <= ch_enable_i[conv_ch_o + 2'h1];
						end
					end
				end
				AAR_DONE: begin
					state_reg <= AAR_IDLE;
					conv_active_o <= 1'b0;
				end
				default: state_reg <= AAR_IDLE;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			aar_result_gate u_gate (
				.alarm_mask_i(alarm_mask_reg),
				.brownout_i(brownout_i),
				.ch_enabled_i(ch_enable_i[g]),
				.flags_i(ch_flags_i[g]),
				.raw_i(ch_raw_i[16*g +: 16]),
				.result_o(gated[16*g +: 16])
			);
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			ch_result_o <= 48'h0;
		else if (ce_i)
			ch_result_o <= gated;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sdo_o <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else if (ce_i) begin
			sdo_oe_o <= rd_phase || sdo_drive_reg;
			sdo_o <= rd_phase ? sdo_bit : 1'b1;
		end
	end

	AST_START_NEEDS_LOCK: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(state_reg == AAR_IDLE && ce_i && !lock_reg) |=> state_reg == AAR_IDLE)
		else $error("start taken without lock");
	AST_MASK_LOCKED: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(ce_i && conv_cfg_reg[BIT_POWER_MODE] && !soft_reset_reg)
		|=> $stable(alarm_mask_reg))
		else $error("alarm mask changed during conversion");
	AST_SOFT_RESET: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(ce_i && soft_reset_reg) |=> alarm_mask_reg == ALARM_MASK_RESET
		&& !sdo_drive_reg && !lock_reg)
		else $error("soft reset left a register set");
	AST_HIZ_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(ce_i && !rd_phase && !sdo_drive_reg) |=> !sdo_oe_o)
		else $error("sdo driven outside read-back");
	AST_DRIVE_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(ce_i && !rd_phase && sdo_drive_reg) |=> sdo_oe_o && sdo_o)
		else $error("sdo not driven high");
	AST_BROWNOUT: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(ce_i && brownout_i && !alarm_mask_reg[BIT_BROWNOUT_MASK]
		&& ch_enable_i[0]) |=> ch_result_o[15:0] == ERROR_CODE)
		else $error("brown-out did not force error code");
	AST_MASKED_PASS: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(ce_i && alarm_mask_reg == ALARM_MASK_WMASK)
		|=> ch_result_o[15:0] == $past(ch_raw_i[15:0]))
		else $error("masked alarm altered result");
	AST_DGAIN_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(ce_i && ch_flags_i[0].dgain_ovr && !alarm_mask_reg[BIT_DGAIN_MASK])
		|=> ch_result_o[15:0] == ERROR_CODE)
		else $error("digital gain over-range not flagged");
	AST_SINGLE_STOP: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(state_reg == AAR_DONE && ce_i) |=> state_reg == AAR_IDLE
		&& !conv_go_o)
		else $error("single shot did not stop");

	// Sequencer entry, wrap and stop, the drive bit writable outside soft reset, read-back and alarm gating
	AST_START_NEEDS_POWER: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		(state_reg == AAR_IDLE && ce_i && !conv_cfg_reg[BIT_POWER_MODE])
		|=> state_reg == AAR_IDLE)
		else $error("start taken in standby");

	AST_START_TAKEN: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		(state_reg == AAR_IDLE && ce_i && start_trig && !soft_reset_reg
		&& ch_enable_i != 3'h0) |=> state_reg == AAR_RUN && conv_active_o)
		else $error("start trigger not taken");

	AST_CONT_WRAP: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		(ce_i && state_reg == AAR_RUN && !soft_reset_reg
		&& conv_cfg_reg[BIT_POWER_MODE] && !conv_cfg_reg[BIT_SINGLE_SHOT]
		&& conv_ch_o == CH_LAST && (conv_done_i || !ch_enable_i[CH_LAST]))
		|=> state_reg == AAR_RUN && conv_ch_o == 2'h0)
		else $error("continuous round robin did not repeat");

	AST_SHOT_END: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		(ce_i && state_reg == AAR_RUN && !soft_reset_reg
		&& conv_cfg_reg[BIT_POWER_MODE] && conv_cfg_reg[BIT_SINGLE_SHOT]
		&& conv_ch_o == CH_LAST && (conv_done_i || !ch_enable_i[CH_LAST]))
		|=> state_reg == AAR_DONE)
		else $error("single shot did not end after last channel");

	AST_SOFT_RESET_STOP: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		(ce_i && soft_reset_reg && state_reg != AAR_IDLE)
		|=> state_reg == AAR_IDLE)
		else $error("soft reset left sequencer running");

	AST_SDO_WRITABLE: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		(ce_i && !soft_reset_reg && hit(req, ADDR_SDO_CFG))
		|=> sdo_drive_reg == $past(req.data[BIT_SDO_DRIVE]))
		else $error("drive bit write refused");

	AST_SDO_READBACK: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		(ce_i && rd_phase)
		|=> sdo_oe_o && sdo_o == $past(sdo_bit))
		else $error("read data not on sdo");

	AST_AMP_ONLY: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		(ce_i && ch_flags_i[1].amp_ovr && !alarm_mask_reg[BIT_AMP_MASK])
		|=> ch_result_o[31:16] == ERROR_CODE)
		else $error("amplifier over-range not flagged");

	AST_BROWNOUT_MASKED: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		(ce_i && brownout_i && alarm_mask_reg[BIT_BROWNOUT_MASK]
		&& !ch_flags_i[0].dgain_ovr && !ch_flags_i[0].amp_ovr)
		|=> ch_result_o[15:0] == $past(ch_raw_i[15:0]))
		else $error("masked brown-out altered result");
endmodule
`default_nettype wire

// *** verification/aar_spi_host.sv ***
// SPI host model: mode 0, 16-bit frames towards the register bank
`timescale 1ns/100ps
`default_nettype none
module aar_spi_host (
	input wire logic clk_i,
	input wire logic sdo_i,
	output logic sclk_o,
	output logic csn_o,
	output logic sdi_o,
	output logic rd_stb_o,
	output logic [7:0] rd_data_o
);
	initial begin
		sclk_o = 1'b0;
		csn_o = 1'b1;
		sdi_o = 1'b0;
		rd_stb_o = 1'b0;
		rd_data_o = 8'h00;
	end
	// Four system cycles per SCLK phase: 800 ns period, slow enough for
	// the two-stage synchronisers on the device side
	task automatic xfer(input logic rd, input logic [6:0] a,
		input logic [7:0] d);
		logic [15:0] f;
		f = {rd, a, d};
		@(negedge clk_i) csn_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi_o = f[i];
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b1;
			repeat (4) @(negedge clk_i);
			// Read data sampled just before SCLK falls again
			if (i < 8) rd_data_o[i] = sdo_i;
			sclk_o = 1'b0;
		end
		repeat (4) @(negedge clk_i);
		csn_o = 1'b1;
		// Deselected line is toggled so a stale level is never trusted
		sdi_o = ~sdi_o;
		rd_stb_o = rd;
		@(negedge clk_i) rd_stb_o = 1'b0;
		repeat (7) @(negedge clk_i);
	endtask
endmodule
`default_nettype wire

// *** verification/aar_regs_tb.sv ***
// Testbench for the alarm mask, drive, soft reset and start bank
`timescale 1ns/100ps
`default_nettype none
module aar_regs_tb;
	import aar_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic brown = 1'b0;
	logic done = 1'b0;
	logic sync = 1'b0;
	logic sclk, csn, sdi, sdo, sdo_oe, rd_stb, go, active;
	logic [7:0] rd_data;
	logic [2:0] ch_en = 3'h0;
	aar_ch_flags_t [2:0] flags = '0;
	logic [47:0] raw = 48'h0;
	logic [47:0] res, expr;
	logic [1:0] ch;
	logic [7:0] exp_q[$];
	int failures = 0;
	int tests_run = 0;
	int ngo = 0;
	int dly = 0;
	wire logic sdo_w;
	assign sdo_w = sdo_oe ? sdo : 1'bz;
	always #50 sys_clk = ~sys_clk;
	aar_regs i_aar_regs (.sys_clk_i(sys_clk), .resetn_i(resetn),
		.ce_i(1'b1), .sclk_i(sclk), .csn_i(csn), .sdi_i(sdi),
		.sdo_o(sdo), .sdo_oe_o(sdo_oe), .sync_i(sync),
		.brownout_i(brown), .ch_enable_i(ch_en), .ch_flags_i(flags),
		.ch_raw_i(raw), .conv_done_i(done), .ch_result_o(res),
		.conv_go_o(go), .conv_ch_o(ch), .conv_active_o(active));
	aar_spi_host i_aar_spi_host (.clk_i(sys_clk), .sdo_i(sdo_w),
		.sclk_o(sclk), .csn_o(csn), .sdi_o(sdi), .rd_stb_o(rd_stb),
		.rd_data_o(rd_data));
	task automatic chk(input logic [47:0] got, exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: %s got %h expected %h", $time, what,
				got, exp);
		end
	endtask
	task automatic results;
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_aar_spi_host.xfer(1'b0, a, d);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_aar_spi_host.xfer(1'b1, a, 8'h00);
	endtask
	always @(posedge rd_stb) chk(rd_data, exp_q.pop_front(), "read");
	// Converter stand-in: finishes each channel after a random delay
	always @(negedge sys_clk) begin
		done = (dly == 1);
		if (dly != 0) dly--;
		if (go === 1'b1) begin
			ngo++;
			dly = $urandom_range(6, 2);
			chk(ch_en[ch], 1'b1, "channel");
		end
	end
	task automatic gate(input logic [7:0] m);
		wr(ADDR_ALARM_MASK, m);
		repeat (8) begin
			@(negedge sys_clk);
			{brown, ch_en} = 4'($urandom);
			flags = 6'($urandom);
			raw = {$urandom, 16'($urandom)};
			for (int g = 0; g < NUM_CH; g++)
				expr[16*g +: 16] = ((brown && ch_en[g] && !m[7]) ||
					(flags[g].dgain_ovr && !m[6]) ||
					(flags[g].amp_ovr && !m[0])) ?
					ERROR_CODE : raw[16*g +: 16];
			@(negedge sys_clk) chk(res, expr, "result");
		end
	endtask
	initial begin
		#2_000_000;
		failures++;
		$display("Error %0t: timeout", $time);
		results;
	end
	initial begin
		void'($urandom(24));
		repeat (10) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		rd(ADDR_ALARM_MASK, ALARM_MASK_RESET);
		rd(ADDR_SDO_CFG, 8'h00);
		rd(ADDR_SOFT_RESET, 8'h00);
		rd(ADDR_START, 8'h00);
		chk(sdo_oe, 1'b0, "sdo idle");
		wr(ADDR_ALARM_MASK, 8'hFF);
		rd(ADDR_ALARM_MASK, ALARM_MASK_WMASK);
		gate(8'h00);
		gate(8'h80);
		gate(8'h40);
		gate(8'h01);
		gate(8'hC1);
		brown = 1'b0;
		ch_en = 3'h5;
		wr(ADDR_SDO_CFG, 8'h01);
		chk({sdo_oe, sdo}, 2'h3, "sdo drive");
		rd(ADDR_SDO_CFG, 8'h01);
		wr(ADDR_CONV_CFG, 8'h01);
		wr(ADDR_ALARM_MASK, 8'h00);
		rd(ADDR_ALARM_MASK, 8'hC1);
		wr(ADDR_SDO_CFG, 8'h00);
		rd(ADDR_SDO_CFG, 8'h00);
		wr(ADDR_START, 8'h80);
		repeat (200) @(negedge sys_clk);
		chk(ngo, 0, "start unlocked");
		wr(ADDR_LOCK, 8'h01);
		wr(ADDR_START, 8'h80);
		repeat (400) @(negedge sys_clk);
		chk(ngo >= 4, 1'b1, "continuous");
		wr(ADDR_SOFT_RESET, 8'h01);
		rd(ADDR_ALARM_MASK, ALARM_MASK_RESET);
		chk(active, 1'b0, "active after reset");
		wr(ADDR_SOFT_RESET, 8'h00);
		rd(ADDR_SOFT_RESET, 8'h00);
		wr(ADDR_CONV_CFG, 8'h03);
		wr(ADDR_LOCK, 8'h01);
		ngo = 0;
		wr(ADDR_START, 8'h80);
		repeat (200) @(negedge sys_clk);
		chk(ngo, 2, "single shot");
		wr(ADDR_START, 8'h80);
		repeat (200) @(negedge sys_clk);
		chk(ngo, 4, "second shot");
		sync = 1'b1;
		repeat (200) @(negedge sys_clk);
		sync = 1'b0;
		chk(ngo, 6, "sync shot");
		results;
	end
endmodule
`default_nettype wire
